// *** core/vram_xfer_consts.svh ***
// timing counts and field positions for the video memory cycle controller
`ifndef VRAM_XFER_CONSTS_SVH
`define VRAM_XFER_CONSTS_SVH
// register offsets on the apb side
`define OFF_CMD        12'h000
`define OFF_ADDR       12'h004
`define OFF_DATA       12'h008
`define OFF_STATUS     12'h00c
`define OFF_SERIAL     12'h010
// command register fields
`define CMD_GO_BIT     4
`define CMD_OP_LSB     0
// status register fields
`define ST_BUSY_BIT    0
`define ST_FLAG_BIT    1
`define ST_RTDONE_BIT  2
`define ST_MWTDONE_BIT 3
`define ST_REFUSED_BIT 4
// strobe phase time in ns, and cycles at 4 ns
`define PHASE_NS       20
`define CLK_NS         4
`define PHASE_CYC      ((`PHASE_NS + `CLK_NS - 1) / `CLK_NS)
// serial clock half period in core cycles
`define SC_HALF_CYC    5
// serial buffer geometry
`define HALF_LAST      9'h0ff
`define FULL_LAST      9'h1ff
`endif

// *** core/vram_xfer_pkg.sv ***
// types for the video memory cycle controller
package vram_xfer_pkg;
   // cycle kinds the controller can issue
   typedef enum logic [3:0] {
      OP_READ_XFER    = 4'h0,
      OP_MASK_WXFER   = 4'h1,
      OP_SPLIT_RXFER  = 4'h2,
      OP_MASK_SWXFER  = 4'h3,
      OP_NORMAL_WR    = 4'h4,
      OP_MASKED_WR    = 4'h5,
      OP_BLOCK_WR     = 4'h6,
      OP_MASK_BLK_WR  = 4'h7,
      OP_FLASH_WR     = 4'h8,
      OP_LOAD_COLOUR  = 4'h9
   } op_t;
   // one-hot sequencer states
   typedef enum logic [5:0] {
      S_IDLE  = 6'b000001,
      S_SETUP = 6'b000010,
      S_ROW   = 6'b000100,
      S_COLS  = 6'b001000,
      S_COL   = 6'b010000,
      S_END   = 6'b100000
   } state_t;
endpackage : vram_xfer_pkg

// *** core/vram_xfer_ctrl.sv ***
// controller driving transfer and write cycles of a dual-port video memory
`timescale 1ns/1ps
`include "vram_xfer_consts.svh"
module vram_xfer_ctrl #(
   parameter int ROW_W = 9,   // row address width
   parameter int COL_W = 9    // column address width
) (
   // clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RST_B,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // memory strobes and address
   output logic             ROW_STROBE_B,
   output logic             COLUMN_STROBE_B,
   output logic             TRANSFER_OUTPUT_ENABLE_B,
   output logic             WRITE_MASK_WRITE_ENABLE_B,
   output logic             SPECIAL_FUNCTION_SELECT,
   output logic [8:0]       MEM_ADDR,
   // mask and data lines, three-signal form
   input  wire logic [7:0]  MASK_DATA_IN,
   output logic      [7:0]  MASK_DATA_OUT,
   output logic             MASK_DATA_OE,
   // serial side
   output logic             SERIAL_SHIFT_CLOCK,
   output logic             SERIAL_PORT_ENABLE_B,
   input  wire logic        SPLIT_HALF_FLAG
);
   // register state
   vram_xfer_pkg::op_t   op_reg, op_next;        // pending cycle kind
   logic [17:0]          addr_reg, addr_next;    // row in high, col in low
   logic [15:0]          data_reg, data_next;    // mask low, data high
   logic                 rt_done_reg, rt_done_next;   // full read seen
   logic                 mwt_done_reg, mwt_done_next; // masked write seen
   logic                 refused_reg, refused_next;   // order or boundary refusal
   logic                 ser_run_reg, ser_run_next;   // serial clock on
   vram_xfer_pkg::state_t st_reg, st_next;       // sequencer state
   logic [7:0]           cnt_reg, cnt_next;      // phase counter
   // sequencer outputs
   logic ras_reg, ras_next, cas_reg, cas_next;
   logic oe_reg, oe_next, we_reg, we_next, dsf_reg, dsf_next;
   logic [8:0] ma_reg, ma_next;
   logic [7:0] dq_reg, dq_next;
   logic       dqoe_reg, dqoe_next;
   // serial clock divider and address model
   logic [7:0] scdiv_reg, scdiv_next;
   logic       sc_reg, sc_next;
   logic [8:0] sptr_reg, sptr_next;
   // synchronised flag from the memory
   logic flag_s1_reg, flag_s2_reg;
   logic busy;
   logic wr_acc, go;
   logic split_op, near_bound;
   assign busy = (st_reg != vram_xfer_pkg::S_IDLE);
   assign wr_acc = PSEL && PENABLE && PWRITE;
   // split transfers: one 256-entry half of the 512 entries moves
   assign split_op = (op_reg == vram_xfer_pkg::OP_SPLIT_RXFER) ||
                     (op_reg == vram_xfer_pkg::OP_MASK_SWXFER);
   // while the serial clock runs, keep split starts clear of the half boundaries; margin is three
   // serial clocks before and two after, ample for the setup and hold limits
   assign near_bound = ser_run_reg &&
      ((sptr_reg[7:0] >= 8'hfd) || (sptr_reg[7:0] <= 8'h01));
   assign go = wr_acc && (PADDR == `OFF_CMD) && PWDATA[`CMD_GO_BIT]
               && !busy;
   // apb answers in the access cycle, no waits
   assign PREADY  = 1'b1;
   assign PSLVERR = 1'b0;
   // read mux
   always_comb begin
      unique case (PADDR)
         `OFF_CMD:    PRDATA = {28'h0, op_reg};
         `OFF_ADDR:   PRDATA = {14'h0, addr_reg};
         `OFF_DATA:   PRDATA = {16'h0, data_reg};
         `OFF_STATUS: PRDATA = {27'h0, refused_reg, mwt_done_reg,
                                rt_done_reg, flag_s2_reg, busy};
         `OFF_SERIAL: PRDATA = {22'h0, ser_run_reg, sptr_reg};
         default:     PRDATA = 32'h0;
      endcase
   end
   // register next values; order checks refuse split cycles early
   always_comb begin
      op_next       = op_reg;
      addr_next     = addr_reg;
      data_next     = data_reg;
      rt_done_next  = rt_done_reg;
      mwt_done_next = mwt_done_reg;
      refused_next  = refused_reg;
      ser_run_next  = ser_run_reg;
      if (wr_acc && PADDR == `OFF_ADDR)
         addr_next = PWDATA[17:0];
      if (wr_acc && PADDR == `OFF_DATA)
         data_next = PWDATA[15:0];
      if (wr_acc && PADDR == `OFF_SERIAL)
         ser_run_next = PWDATA[0];
      if (wr_acc && PADDR == `OFF_STATUS && PWDATA[`ST_REFUSED_BIT])
         refused_next = 1'b0;
      if (go)
         op_next = vram_xfer_pkg::op_t'(PWDATA[3:0]);
      if (st_reg == vram_xfer_pkg::S_END && cnt_reg == 8'h0) begin
         if (op_reg == vram_xfer_pkg::OP_READ_XFER)
            rt_done_next = 1'b1;
         if (op_reg == vram_xfer_pkg::OP_MASK_WXFER)
            mwt_done_next = 1'b1;
      end
      // refusal set wins over a software clear in the same cycle
      if (st_reg == vram_xfer_pkg::S_SETUP && ((split_op && near_bound)
          || (op_reg == vram_xfer_pkg::OP_SPLIT_RXFER && !rt_done_reg)
          || (op_reg == vram_xfer_pkg::OP_MASK_SWXFER && !mwt_done_reg)))
         refused_next = 1'b1;
   end
   // strobe sequencer: setup, row fall, column setup, column fall, end
   always_comb begin
      st_next = st_reg;
      cnt_next = (cnt_reg == 8'h0) ? 8'h0 : cnt_reg - 8'h1;
      ras_next = ras_reg;
      cas_next = cas_reg;
      oe_next = oe_reg;
      we_next = we_reg;
      dsf_next = dsf_reg;
      ma_next = ma_reg;
      dq_next = dq_reg;
      dqoe_next = dqoe_reg;
      unique case (st_reg)
         vram_xfer_pkg::S_IDLE: begin
            if (go) begin
               st_next = vram_xfer_pkg::S_SETUP;
               cnt_next = 8'(`PHASE_CYC);
            end
         end
         vram_xfer_pkg::S_SETUP: begin
            if ((split_op && near_bound)
                || (op_reg == vram_xfer_pkg::OP_SPLIT_RXFER && !rt_done_reg)
                || (op_reg == vram_xfer_pkg::OP_MASK_SWXFER
                    && !mwt_done_reg)) begin
               st_next = vram_xfer_pkg::S_IDLE;
            end else if (cnt_reg == 8'h0) begin
               // row address and row-fall levels
               ma_next = addr_reg[17:9];
               dq_next = data_reg[7:0];
               dqoe_next = 1'b1;
               unique case (op_reg)
                  vram_xfer_pkg::OP_READ_XFER: begin
                     oe_next = 1'b0; we_next = 1'b1; dsf_next = 1'b0;
                  end
                  vram_xfer_pkg::OP_MASK_WXFER: begin
                     oe_next = 1'b0; we_next = 1'b0; dsf_next = 1'b0;
                  end
                  vram_xfer_pkg::OP_SPLIT_RXFER: begin
                     oe_next = 1'b0; we_next = 1'b1; dsf_next = 1'b1;
                  end
                  vram_xfer_pkg::OP_MASK_SWXFER: begin
                     oe_next = 1'b0; we_next = 1'b0; dsf_next = 1'b1;
                  end
                  vram_xfer_pkg::OP_MASKED_WR,
                  vram_xfer_pkg::OP_MASK_BLK_WR: begin
                     oe_next = 1'b1; we_next = 1'b0; dsf_next = 1'b0;
                  end
                  vram_xfer_pkg::OP_FLASH_WR: begin
                     oe_next = 1'b1; we_next = 1'b0; dsf_next = 1'b1;
                  end
                  vram_xfer_pkg::OP_LOAD_COLOUR: begin
                     oe_next = 1'b1; we_next = 1'b1; dsf_next = 1'b1;
                  end
                  default: begin
                     oe_next = 1'b1; we_next = 1'b1; dsf_next = 1'b0;
                  end
               endcase
               st_next = vram_xfer_pkg::S_ROW;
               cnt_next = 8'(`PHASE_CYC);
            end
         end
         vram_xfer_pkg::S_ROW: begin
            // row strobe falls here; levels above sampled
            ras_next = 1'b0;
            if (cnt_reg == 8'h0) begin
               st_next = vram_xfer_pkg::S_COLS;
               cnt_next = 8'(`PHASE_CYC);
               ma_next = addr_reg[8:0];
               if (op_reg == vram_xfer_pkg::OP_SPLIT_RXFER ||
                   op_reg == vram_xfer_pkg::OP_MASK_SWXFER)
                  ma_next = {1'b0, addr_reg[7:0]};
               if (op_reg == vram_xfer_pkg::OP_BLOCK_WR ||
                   op_reg == vram_xfer_pkg::OP_MASK_BLK_WR)
                  ma_next = {addr_reg[8:2], 2'b00};
               // transfer enable and flash need no column data
               dqoe_next = (op_reg != vram_xfer_pkg::OP_FLASH_WR) &&
                           !(op_reg inside {vram_xfer_pkg::OP_READ_XFER,
                             vram_xfer_pkg::OP_MASK_WXFER,
                             vram_xfer_pkg::OP_SPLIT_RXFER,
                             vram_xfer_pkg::OP_MASK_SWXFER});
               dq_next = data_reg[15:8];
               if (op_reg == vram_xfer_pkg::OP_BLOCK_WR ||
                   op_reg == vram_xfer_pkg::OP_MASK_BLK_WR)
                  dq_next = {4'h0, data_reg[11:8]};
               // column-fall select: block write and colour load high
               dsf_next = (op_reg == vram_xfer_pkg::OP_BLOCK_WR) ||
                          (op_reg == vram_xfer_pkg::OP_MASK_BLK_WR) ||
                          (op_reg == vram_xfer_pkg::OP_LOAD_COLOUR);
               // early write only, so block writes are never late
               if (op_reg inside {vram_xfer_pkg::OP_NORMAL_WR,
                   vram_xfer_pkg::OP_MASKED_WR, vram_xfer_pkg::OP_BLOCK_WR,
                   vram_xfer_pkg::OP_MASK_BLK_WR,
                   vram_xfer_pkg::OP_LOAD_COLOUR})
                  we_next = 1'b0;
            end
         end
         vram_xfer_pkg::S_COLS: begin
            if (cnt_reg == 8'h0) begin
               st_next = vram_xfer_pkg::S_COL;
               cnt_next = 8'(`PHASE_CYC);
            end
         end
         vram_xfer_pkg::S_COL: begin
            cas_next = 1'b0;
            if (cnt_reg == 8'h0) begin
               // output enable rises after column fall: untimed transfer
               oe_next = 1'b1;
               st_next = vram_xfer_pkg::S_END;
               cnt_next = 8'(`PHASE_CYC);
            end
         end
         vram_xfer_pkg::S_END: begin
            ras_next = 1'b1;
            cas_next = 1'b1;
            we_next = 1'b1;
            dsf_next = 1'b0;
            dqoe_next = 1'b0;
            if (cnt_reg == 8'h0)
               st_next = vram_xfer_pkg::S_IDLE;
         end
         default: st_next = vram_xfer_pkg::S_IDLE;
      endcase
   end
   // serial clock divider and local address mirror
   always_comb begin
      scdiv_next = scdiv_reg;
      sc_next = sc_reg;
      sptr_next = sptr_reg;
      if (ser_run_reg) begin
         scdiv_next = scdiv_reg + 8'h1;
         if (scdiv_reg == 8'(`SC_HALF_CYC - 1)) begin
            scdiv_next = 8'h0;
            sc_next = !sc_reg;
            if (!sc_reg)
               sptr_next = sptr_reg + 9'h1;
         end
      end
      // a full read or masked write transfer restarts the mirror at the tap
      if (st_reg == vram_xfer_pkg::S_END && cnt_reg == 8'h0 &&
          (op_reg == vram_xfer_pkg::OP_READ_XFER ||
           op_reg == vram_xfer_pkg::OP_MASK_WXFER))
         sptr_next = addr_reg[8:0];
   end
   // flip-flops
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         op_reg <= vram_xfer_pkg::OP_READ_XFER;
         addr_reg <= 18'h0;
         data_reg <= 16'h0;
         rt_done_reg <= 1'b0;
         mwt_done_reg <= 1'b0;
         refused_reg <= 1'b0;
         ser_run_reg <= 1'b0;
         st_reg <= vram_xfer_pkg::S_IDLE;
         cnt_reg <= 8'h0;
         ras_reg <= 1'b1;
         cas_reg <= 1'b1;
         oe_reg <= 1'b1;
         we_reg <= 1'b1;
         dsf_reg <= 1'b0;
         ma_reg <= 9'h0;
         dq_reg <= 8'h0;
         dqoe_reg <= 1'b0;
         scdiv_reg <= 8'h0;
         sc_reg <= 1'b0;
         sptr_reg <= 9'h0;
         flag_s1_reg <= 1'b0;
         flag_s2_reg <= 1'b0;
      end else begin
         op_reg <= op_next;
         addr_reg <= addr_next;
         data_reg <= data_next;
         rt_done_reg <= rt_done_next;
         mwt_done_reg <= mwt_done_next;
         refused_reg <= refused_next;
         ser_run_reg <= ser_run_next;
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         ras_reg <= ras_next;
         cas_reg <= cas_next;
         oe_reg <= oe_next;
         we_reg <= we_next;
         dsf_reg <= dsf_next;
         ma_reg <= ma_next;
         dq_reg <= dq_next;
         dqoe_reg <= dqoe_next;
         scdiv_reg <= scdiv_next;
         sc_reg <= sc_next;
         sptr_reg <= sptr_next;
         flag_s1_reg <= SPLIT_HALF_FLAG;
         flag_s2_reg <= flag_s1_reg;
      end
   end
   // pins from registers; serial port enable tied low
   assign ROW_STROBE_B = ras_reg;
   assign COLUMN_STROBE_B = cas_reg;
   assign TRANSFER_OUTPUT_ENABLE_B = oe_reg;
   assign WRITE_MASK_WRITE_ENABLE_B = we_reg;
   assign SPECIAL_FUNCTION_SELECT = dsf_reg;
   assign MEM_ADDR = ma_reg;
   assign MASK_DATA_OUT = dq_reg;
   assign MASK_DATA_OE = dqoe_reg;
   assign SERIAL_SHIFT_CLOCK = sc_reg;
   assign SERIAL_PORT_ENABLE_B = 1'b0;
endmodule : vram_xfer_ctrl

// *** tb/vram_xfer_ctrl_sva.sv ***
// assertions on the memory-side pins of the video memory controller
`timescale 1ns/1ps
module vram_xfer_ctrl_sva (
   // clock and reset
   input wire logic       CORE_CLK,
   input wire logic       RST_B,
   // strobes, levels, address and data enable
   input wire logic       ROW_STROBE_B,
   input wire logic       COLUMN_STROBE_B,
   input wire logic       TRANSFER_OUTPUT_ENABLE_B,
   input wire logic       WRITE_MASK_WRITE_ENABLE_B,
   input wire logic       SPECIAL_FUNCTION_SELECT,
   input wire logic [8:0] MEM_ADDR,
   input wire logic       MASK_DATA_OE,
   // serial side
   input wire logic       SERIAL_SHIFT_CLOCK,
   input wire logic       SERIAL_PORT_ENABLE_B
);
   logic oe_row_reg;   // output enable level kept from row fall
   logic dsf_row_reg;  // select level kept from row fall
   // keep row-fall levels so the column fall knows the cycle kind
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         oe_row_reg  <= 1'b1;
         dsf_row_reg <= 1'b0;
      end else if ($fell(ROW_STROBE_B)) begin
         oe_row_reg  <= TRANSFER_OUTPUT_ENABLE_B;
         dsf_row_reg <= SPECIAL_FUNCTION_SELECT;
      end
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);
   // strobe falls, and a block write column fall
   sequence ras_fall;
      $fell(ROW_STROBE_B);
   endsequence
   sequence cas_fall;
      $fell(COLUMN_STROBE_B);
   endsequence
   sequence blk_fall;
      cas_fall ##0 (oe_row_reg && !dsf_row_reg && SPECIAL_FUNCTION_SELECT);
   endsequence
   levels_setup_a: assert property (ras_fall |->
      $stable({TRANSFER_OUTPUT_ENABLE_B, WRITE_MASK_WRITE_ENABLE_B,
               SPECIAL_FUNCTION_SELECT}))
      else $error("cycle levels moved at row fall");
   row_addr_a: assert property (ras_fall |-> $stable(MEM_ADDR))
      else $error("row address moved at row fall");
   col_addr_a: assert property (cas_fall |-> $stable(MEM_ADDR))
      else $error("column address moved at column fall");
   cas_in_ras_a: assert property (cas_fall |-> !ROW_STROBE_B)
      else $error("column fall outside a row cycle");
   mask_at_row_a: assert property (
      ras_fall ##0 !WRITE_MASK_WRITE_ENABLE_B |-> MASK_DATA_OE)
      else $error("plane mask not driven at row fall");
   mwt_se_low_a: assert property (ras_fall ##0
      !(TRANSFER_OUTPUT_ENABLE_B | WRITE_MASK_WRITE_ENABLE_B |
        SPECIAL_FUNCTION_SELECT) |-> !SERIAL_PORT_ENABLE_B)
      else $error("write transfer with serial port disabled");
   blk_mask_a: assert property (blk_fall |->
      MASK_DATA_OE && MEM_ADDR[1:0] == 2'b00)
      else $error("block write column mask or address wrong");
   sc_low_a: assert property ($fell(SERIAL_SHIFT_CLOCK) |->
      !SERIAL_SHIFT_CLOCK[*5])
      else $error("serial clock low phase too short");
endmodule : vram_xfer_ctrl_sva

// *** tb/vram_dev_model.sv ***
// behavioural model of the dual-port video memory behind the controller
`timescale 1ns/1ps
module vram_dev_model #(
   parameter int WIN = 1   // guard steps before a half boundary
) (
   // strobes, address and data lines
   input  wire logic       ras_b,
   input  wire logic       cas_b,
   input  wire logic       transfer_output_enable_b,
   input  wire logic       write_mask_write_enable_b,
   input  wire logic       special_function_select,
   input  wire logic [8:0] addr,
   input  wire logic [7:0] mask_data_lines,
   // serial side
   input  wire logic       serial_shift_clock,
   output logic            split_half_flag,
   // decoded cycle record for the bench
   output logic [37:0]     ev,
   output int              ev_cnt,
   output int              viol,
   output logic [8:0]      cnt
);
   logic [2:0] lvl;      // enable, write, select levels at row fall
   logic [8:0] row;      // row address
   logic [7:0] pmask;    // plane mask from row fall
   logic [3:0] op;       // decoded cycle kind
   logic [8:0] pend;     // split start waiting for its boundary
   logic       pend_ok;  // a split start is pending
   logic       rt_seen;  // a full read transfer happened
   logic       wt_seen;  // a masked write transfer happened
   logic       port_in;  // serial port direction, high for input
   logic       nh;       // half entered at a boundary
   // power-up state; flag only meaningful after a full transfer
   initial begin
      {split_half_flag, pend_ok, rt_seen, wt_seen, port_in} = 5'h00;
      ev_cnt = 0;
      viol = 0;
      cnt = 9'h000;
   end
   // row fall latches levels, row and plane mask
   always @(negedge ras_b) begin
      lvl = {transfer_output_enable_b, write_mask_write_enable_b,
             special_function_select};
      row = addr;
      pmask = mask_data_lines;
   end
   // column fall finishes the decode and applies its side effects
   always @(negedge cas_b) begin
      if (!lvl[2])
         op = lvl[0] ? (lvl[1] ? 4'h2 : 4'h3) : (lvl[1] ? 4'h0 : 4'h1);
      else if (lvl[0])
         op = lvl[1] ? 4'h9 : 4'h8;
      else
         op = {2'b01, special_function_select, !lvl[1]};
      case (op)
         4'h0, 4'h1: begin
            cnt = addr;
            split_half_flag = addr[8];
            rt_seen = rt_seen | (op == 4'h0);
            wt_seen = wt_seen | (op == 4'h1);
            port_in = (op == 4'h1);
            pend_ok = 1'b0;
         end
         4'h2, 4'h3: begin
            // a split request too near a boundary or out of order counts
            if ((op == 4'h2 ? !rt_seen : !wt_seen) ||
                int'(cnt[7:0]) + WIN > 255)
               viol++;
            pend = {~split_half_flag, addr[7:0]};
            pend_ok = 1'b1;
         end
         default: ;
      endcase
      ev = {op, row, addr, pmask, mask_data_lines};
      ev_cnt++;
   end
   // each serial clock rise steps the counter; halves switch at 255, 511
   always @(posedge serial_shift_clock) begin
      if (cnt[7:0] == 8'hff) begin
         nh = ~cnt[8];
         cnt = (pend_ok && pend[8] == nh) ? pend : {nh, 8'h00};
         pend_ok = pend_ok && pend[8] != nh;
         split_half_flag = nh;
      end else
         cnt = cnt + 9'h001;
   end
endmodule : vram_dev_model

// *** tb/video_dram_transfer_and_write_decode_tb_top.sv ***
// self-checking bench for the video memory transfer and write controller
`timescale 1ns/1ps
`include "vram_xfer_consts.svh"
module video_dram_transfer_and_write_decode_tb_top;
   logic        core_clk = 1'b0;   // 250 MHz core clock
   logic        rst_b    = 1'b0;   // reset, active low
   logic        psel     = 1'b0;   // apb request
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [11:0] paddr    = 12'h000;
   logic [31:0] pwdata   = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr;
   logic        ras_b, cas_b, xoe_b, wme_b, sfs;  // strobes and levels
   logic [8:0]  maddr;             // row then column
   logic [7:0]  dq_out, dq_line;   // driven value, wire level
   logic        dq_oe, ssc, spe_b, shf;
   logic [37:0] ev;                // last decoded cycle
   int          ev_cnt, viol;
   logic [8:0]  dev_cnt;           // device serial address
   logic [75:0] exp_q[$];          // mask and value of awaited cycles
   int          bad_count = 0;
   int          n_checks  = 0;
   integer      seed      = 32'hb71c;
   // released lines show the inverse of the last value, not a stale copy
   assign dq_line = dq_oe ? dq_out : ~dq_out;
   initial begin
      forever #2 core_clk = ~core_clk;
   end
   vram_xfer_ctrl dut_u (.CORE_CLK(core_clk), .RST_B(rst_b), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .ROW_STROBE_B(ras_b), .COLUMN_STROBE_B(cas_b),
      .TRANSFER_OUTPUT_ENABLE_B(xoe_b), .WRITE_MASK_WRITE_ENABLE_B(wme_b),
      .SPECIAL_FUNCTION_SELECT(sfs), .MEM_ADDR(maddr),
      .MASK_DATA_IN(dq_line), .MASK_DATA_OUT(dq_out), .MASK_DATA_OE(dq_oe),
      .SERIAL_SHIFT_CLOCK(ssc), .SERIAL_PORT_ENABLE_B(spe_b),
      .SPLIT_HALF_FLAG(shf));
   vram_dev_model mdl_u (.ras_b(ras_b), .cas_b(cas_b),
      .transfer_output_enable_b(xoe_b), .write_mask_write_enable_b(wme_b),
      .special_function_select(sfs), .addr(maddr), .mask_data_lines(dq_line),
      .serial_shift_clock(ssc), .split_half_flag(shf), .ev(ev),
      .ev_cnt(ev_cnt), .viol(viol), .cnt(dev_cnt));
   task automatic tally_and_finish();
      if (bad_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   task automatic give_up();
      bad_count++;
      tally_and_finish();
   endtask : give_up
   task automatic check(input logic [37:0] got, input logic [37:0] want);
      n_checks++;
      if (got !== want) begin
         bad_count++;
         $display("[FAIL] %0t got %h want %h", $time, got, want);
      end
   endtask : check
   // one apb transfer, request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int k;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) give_up();
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] m,
                         input logic [31:0] want);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      check({6'h0, r & m}, {6'h0, want});
   endtask : rd_chk
   // issue one memory cycle, note what the device should see, await idle
   task automatic run_op(input logic [3:0] op, input logic [8:0] col,
                         input logic refuse);
      logic [31:0] d, r;
      logic [8:0]  row, ecol;
      logic [37:0] m;
      int          k;
      d = $random(seed);
      row = 9'($random(seed));
      ecol = (op inside {4'h6, 4'h7}) ? {col[8:2], 2'b00} : col;
      m = {13'h1fff, (op inside {4'h2, 4'h3}) ? 9'h0ff : 9'h1ff, 16'h0};
      if (op == 4'h8)
         m[24:16] = 9'h000;
      if (op inside {4'h1, 4'h3, 4'h5, 4'h7, 4'h8})
         m[15:8] = 8'hff;
      if (op inside {4'h4, 4'h5, 4'h9})
         m[7:0] = 8'hff;
      else if (op inside {4'h6, 4'h7})
         m[7:0] = 8'h0f;
      if (!refuse)
         exp_q.push_back({m, m & {op, row, ecol, d[7:0], d[15:8]}});
      apb(1'b1, `OFF_ADDR, {14'h0, row, col}, r);
      apb(1'b1, `OFF_DATA, d, r);
      apb(1'b1, `OFF_CMD, {27'h0, 1'b1, op}, r);
      k = 0;
      do begin
         apb(1'b0, `OFF_STATUS, 32'h0, r);
         k++;
      end while (r[`ST_BUSY_BIT] !== 1'b0 && k < 40);
      if (k >= 40) give_up();
      check({37'h0, r[`ST_REFUSED_BIT]}, {37'h0, refuse});
      apb(1'b1, `OFF_STATUS, 32'h10, r);
   endtask : run_op
   // each decoded memory cycle meets the oldest expectation
   initial begin
      logic [75:0] e;
      forever begin
         @(ev_cnt);
         if (exp_q.size() == 0)
            check(ev, ~ev);
         else begin
            e = exp_q.pop_front();
            check(ev & e[75:38], e[37:0]);
         end
      end
   end
   initial begin
      logic [31:0] r;
      int          k;
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      run_op(4'h2, 9'h020, 1'b1);
      run_op(4'h3, 9'h020, 1'b1);
      for (int i = 0; i < 10; i++)
         run_op(4'(i), (i < 2) ? 9'h010 | 9'($random(seed) & 127)
                               : 9'($random(seed)), 1'b0);
      rd_chk(`OFF_STATUS, 32'h0c, 32'h0c);
      run_op(4'h1, 9'h180, 1'b0);
      rd_chk(`OFF_STATUS, 32'h02, 32'h02);
      // the boundary guard only acts while the serial clock runs
      apb(1'b1, `OFF_SERIAL, 32'h1, r);
      run_op(4'h0, 9'h0fe, 1'b0);
      run_op(4'h2, 9'h033, 1'b1);
      // stop shifting so the mirror and the device restart together
      apb(1'b1, `OFF_SERIAL, 32'h0, r);
      run_op(4'h0, 9'h0f0, 1'b0);
      run_op(4'h2, 9'h044, 1'b0);
      run_op(4'h2, 9'h033, 1'b0);
      apb(1'b1, `OFF_SERIAL, 32'h1, r);
      k = 0;
      do begin
         apb(1'b0, `OFF_STATUS, 32'h0, r);
         k++;
      end while (r[`ST_FLAG_BIT] !== 1'b1 && k < 300);
      if (k >= 300) give_up();
      apb(1'b1, `OFF_SERIAL, 32'h0, r);
      repeat (40) @(posedge core_clk);
      // mirror steps on past 0x100; the device jumped to the split tap
      apb(1'b0, `OFF_SERIAL, 32'h0, r);
      check({29'h0, dev_cnt}, {29'h0, r[8:0] + 9'h033});
      rd_chk(`OFF_STATUS, 32'h02, 32'h02);
      rd_chk(12'h020, 32'hffffffff, 32'h0);
      check(38'(exp_q.size()), 38'h0);
      check(38'(viol), 38'h0);
      tally_and_finish();
   end
   initial begin
      repeat (100000) @(posedge core_clk);
      give_up();
   end
endmodule : video_dram_transfer_and_write_decode_tb_top
bind vram_xfer_ctrl vram_xfer_ctrl_sva chk_u (.CORE_CLK, .RST_B,
   .ROW_STROBE_B, .COLUMN_STROBE_B, .TRANSFER_OUTPUT_ENABLE_B,
   .WRITE_MASK_WRITE_ENABLE_B, .SPECIAL_FUNCTION_SELECT, .MEM_ADDR,
   .MASK_DATA_OE, .SERIAL_SHIFT_CLOCK, .SERIAL_PORT_ENABLE_B);
